/* File: rtl/timer2_control_logic.sv */
// Functional notes
// RQ1: High flag set on upper byte rollover
// RQ2: Enabled high flag requests interrupt; software clears
// RQ3: Low flag set on low rollover, sticky
// RQ4: Low byte enable adds low overflow interrupts
// RQ5: Capture copies count to reload, interrupts
// RQ6: Split bit chooses 16-bit or two 8-bit
// RQ7: Run gates counting; split gates high only
// RQ8: Bit 1 reads zero, writes ignored
// RQ9: Timebase sys divided 12 or ext 8
// RQ10: Timebase shared by both split bytes
// RQ11: Control at 0xc8, bit access, reset zero
// RQ12: 16-bit wrap loads reload pair
// RQ13: Split bytes reload from own bytes
// RQ14: Clock select 1 picks undivided clock
// RQ15: Software checks both flags for source
// RQ16: Synchronise oscillator, falling edge one strobe
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
module timer2_control_logic (
  input  wire logic                clk_in,
  input  wire logic                resetn_in,
  input  wire timer2_pkg::wb_req_s wb_req_in,
  output timer2_pkg::wb_rsp_s      wb_rsp_out,
  input  wire logic                ext_osc_in,
  input  wire logic                low_freq_oscillator_in,
  output logic                     irq_out
);

  // ==========================================================================
  // Declarations
  timer2_pkg::ctrl_s   ctrl;
  timer2_pkg::ctrl_s   next_ctrl;
  timer2_pkg::clksel_s clksel;
  logic [timer2_pkg::IRQ_BITS-1:0] irq_status;
  logic [timer2_pkg::IRQ_BITS-1:0] next_irq_status;
  logic [timer2_pkg::IRQ_BITS-1:0] irq_enable;
  logic [timer2_pkg::IRQ_BITS-1:0] irq_events;
  logic [timer2_pkg::IRQ_BITS-1:0] irq_clear_mask;
  logic [timer2_pkg::IRQ_BITS-1:0] irq_gate;
  logic [7:0]  reload_low;
  logic [7:0]  reload_high;
  logic [7:0]  count_low;
  logic [7:0]  count_high;
  logic        low_carry;
  logic        high_carry;
  logic        low_inc;
  logic        high_inc;
  logic        low_reload_on_wrap;
  logic [3:0]  sys_div;
  logic        sys_tick;
  logic [2:0]  ext_div;
  logic        ext_rise;
  logic        ext_tick;
  logic        timebase_tick;
  logic        low_tick;
  logic        high_tick;
  logic        osc_fall;
  logic        capture_fire;
  logic        ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        req;
  logic        wr_fire;
  logic        lane0;
  logic        lane1;
  logic        hit_ctrl;
  logic        hit_reload;
  logic        hit_count;
  logic        hit_clksel;
  logic        hit_status;
  logic        hit_clear;
  logic        hit_enable;
  logic        hit_set;
  logic        hit_clr;
  logic        wr_ctrl;
  logic        wr_set;
  logic        wr_clr;
  logic [7:0]  wbyte0;
  logic [7:0]  wbyte1;

  // ==========================================================================
  // Wishbone slave handshake
  assign req     = wb_req_in.cyc & wb_req_in.stb;
  assign wr_fire = req & wb_req_in.we & ack;
  assign lane0   = wb_req_in.sel[0];
  assign lane1   = wb_req_in.sel[1];
  assign wbyte0  = wb_req_in.dat[7:0];
  assign wbyte1  = wb_req_in.dat[15:8];

  // Address decode
  assign hit_ctrl   = (wb_req_in.adr == timer2_pkg::CTRL_ADDR);   // RQ11
  assign hit_reload = (wb_req_in.adr == timer2_pkg::RELOAD_ADDR);
  assign hit_count  = (wb_req_in.adr == timer2_pkg::COUNT_ADDR);
  assign hit_clksel = (wb_req_in.adr == timer2_pkg::CLKSEL_ADDR);
  assign hit_status = (wb_req_in.adr == timer2_pkg::IRQ_STATUS_ADDR);
  assign hit_clear  = (wb_req_in.adr == timer2_pkg::IRQ_CLEAR_ADDR);
  assign hit_enable = (wb_req_in.adr == timer2_pkg::IRQ_ENABLE_ADDR);
  assign hit_set    = (wb_req_in.adr == timer2_pkg::CTRL_SET_ADDR);
  assign hit_clr    = (wb_req_in.adr == timer2_pkg::CTRL_CLR_ADDR);

  // Control write strobes, whole byte or bit-set and bit-clear aliases
  assign wr_ctrl = wr_fire & hit_ctrl & lane0;
  assign wr_set  = wr_fire & hit_set & lane0;   // RQ11
  assign wr_clr  = wr_fire & hit_clr & lane0;   // RQ11

  // Ack one cycle after request, dropped after one cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Read mux; unmapped addresses and the irq clear register read zero, set and clear aliases read control
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_rdata[7:0] = ctrl;
    end
    if (hit_set | hit_clr) begin
      next_rdata[7:0] = ctrl;
    end
    if (hit_reload) begin
      next_rdata[15:0] = {reload_high, reload_low};
    end
    if (hit_count) begin
      next_rdata[15:0] = {count_high, count_low};
    end
    if (hit_clksel) begin
      next_rdata[1:0] = clksel;
    end
    if (hit_status) begin
      next_rdata[timer2_pkg::IRQ_BITS-1:0] = irq_status;
    end
    if (hit_enable) begin
      next_rdata[timer2_pkg::IRQ_BITS-1:0] = irq_enable;
    end
  end

  // Read data latched as a read's ack rises; writes leave it held
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata <= 32'h0000_0000;
    end else if (req & ~ack & ~wb_req_in.we) begin
      rdata <= next_rdata;
    end
  end

  assign wb_rsp_out = '{ack: ack, dat: rdata};

  // ==========================================================================
  // Timebase generation
  // System clock divided by 12
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sys_div <= 4'h0;
    end else if (sys_div == timer2_pkg::SYS_DIV_LAST) begin
      sys_div <= 4'h0;
    end else begin
      sys_div <= sys_div + 4'h1;
    end
  end

  assign sys_tick = (sys_div == timer2_pkg::SYS_DIV_LAST);   // RQ9

  // External oscillator brought into the system clock domain
  sync_edge ext_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (ext_osc_in),
    .rise_out  (ext_rise),
    .fall_out  ()
  );

  // External clock divided by 8
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_div <= 3'h0;
    end else if (ext_rise) begin
      ext_div <= ext_div + 3'h1;
    end
  end

  assign ext_tick = ext_rise & (ext_div == timer2_pkg::EXT_DIV_LAST);   // RQ9

  // Shared timebase, then per-byte clock select
  assign timebase_tick = ctrl.ext_timebase_select ? ext_tick : sys_tick;   // RQ9
  assign low_tick  = clksel.low_byte_clock_select  ? 1'b1 : timebase_tick;   // RQ14
  assign high_tick = clksel.high_byte_clock_select ? 1'b1 : timebase_tick;   // RQ10

  // ==========================================================================
  // Counter structure
  // Increment enables per mode
  always_comb begin
    if (ctrl.split_mode_select) begin
      low_inc  = low_tick;   // RQ7
      high_inc = ctrl.run_control & high_tick;   // RQ7
    end else begin
      low_inc  = ctrl.run_control & low_tick;   // RQ7
      high_inc = low_carry;   // RQ6
    end
  end

  // Low byte reloads alone in split mode, only on full wrap otherwise
  assign low_reload_on_wrap = ctrl.split_mode_select | (count_high == timer2_pkg::BYTE_MAX);   // RQ12

  byte_counter low_byte (
    .clk_in            (clk_in),
    .resetn_in         (resetn_in),
    .inc_in            (low_inc),
    .reload_on_wrap_in (low_reload_on_wrap),
    .reload_value_in   (reload_low),   // RQ13
    .write_in          (wr_fire & hit_count & lane0),
    .write_value_in    (wbyte0),
    .count_out         (count_low),
    .carry_out         (low_carry)
  );

  byte_counter high_byte (
    .clk_in            (clk_in),
    .resetn_in         (resetn_in),
    .inc_in            (high_inc),
    .reload_on_wrap_in (1'b1),
    .reload_value_in   (reload_high),   // RQ13
    .write_in          (wr_fire & hit_count & lane1),
    .write_value_in    (wbyte1),
    .count_out         (count_high),
    .carry_out         (high_carry)
  );

  // ==========================================================================
  // Low-frequency oscillator capture
  sync_edge osc_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (low_freq_oscillator_in),
    .rise_out  (),
    .fall_out  (osc_fall)   // RQ16
  );

  assign capture_fire = ctrl.lfo_capture_enable & osc_fall;   // RQ5

  // Reload pair; capture wins over a software write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reload_low  <= timer2_pkg::BYTE_ZERO;
      reload_high <= timer2_pkg::BYTE_ZERO;
    end else if (capture_fire) begin
      reload_low  <= count_low;   // RQ5
      reload_high <= count_high;   // RQ5
    end else begin
      if (wr_fire & hit_reload & lane0) begin
        reload_low <= wbyte0;
      end
      if (wr_fire & hit_reload & lane1) begin
        reload_high <= wbyte1;
      end
    end
  end

  // ==========================================================================
  // Control register
  // Software update first, hardware flag sets override it
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = timer2_pkg::ctrl_s'(wbyte0 & timer2_pkg::CTRL_WRITE_MASK);   // RQ11
    end else if (wr_set) begin
      next_ctrl = timer2_pkg::ctrl_s'(ctrl | (wbyte0 & timer2_pkg::CTRL_WRITE_MASK));
    end else if (wr_clr) begin
      next_ctrl = timer2_pkg::ctrl_s'(ctrl & ~(wbyte0 & timer2_pkg::CTRL_WRITE_MASK));
    end
    next_ctrl.unused_bit = 1'b0;   // RQ8
    if (high_carry | capture_fire) begin
      next_ctrl.high_overflow_flag = 1'b1;   // RQ1
    end
    if (low_carry) begin
      next_ctrl.low_overflow_flag = 1'b1;   // RQ3
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl <= timer2_pkg::ctrl_s'(timer2_pkg::CTRL_RESET);   // RQ11
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Per-byte clock select register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clksel <= timer2_pkg::clksel_s'(timer2_pkg::CLKSEL_RESET);
    end else if (wr_fire & hit_clksel & lane0) begin
      clksel <= timer2_pkg::clksel_s'(wbyte0[1:0]);   // RQ14
    end
  end

  // ==========================================================================
  // Interrupts
  // Events: high overflow, low overflow, capture
  always_comb begin
    irq_events = timer2_pkg::IRQ_RESET;
    irq_events[timer2_pkg::IRQ_HIGH]    = high_carry | capture_fire;   // RQ2
    irq_events[timer2_pkg::IRQ_LOW]     = low_carry;   // RQ4
    irq_events[timer2_pkg::IRQ_CAPTURE] = capture_fire;   // RQ5
  end

  assign irq_clear_mask = (wr_fire & hit_clear & lane0) ? wbyte0[timer2_pkg::IRQ_BITS-1:0] : timer2_pkg::IRQ_RESET;

  // Sticky status; a new event wins over a clear
  assign next_irq_status = (irq_status & ~irq_clear_mask) | irq_events;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_status <= timer2_pkg::IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_enable <= timer2_pkg::IRQ_RESET;
    end else if (wr_fire & hit_enable & lane0) begin
      irq_enable <= wbyte0[timer2_pkg::IRQ_BITS-1:0];
    end
  end

  // Low overflow only interrupts when the low-byte enable is set
  always_comb begin
    irq_gate = irq_enable;
    irq_gate[timer2_pkg::IRQ_LOW] = irq_enable[timer2_pkg::IRQ_LOW] & ctrl.low_byte_irq_enable;   // RQ4
  end

  // Level interrupt while any enabled status bit is set
  assign irq_out = |(irq_status & irq_gate);   // RQ2

endmodule // timer2_control_logic

/* File: rtl/timer2_pkg.sv */
package timer2_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR       = 8'hc8;
  localparam logic [7:0] RELOAD_ADDR     = 8'hd0;
  localparam logic [7:0] COUNT_ADDR      = 8'hd4;
  localparam logic [7:0] CLKSEL_ADDR     = 8'hd8;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'hdc;
  localparam logic [7:0] IRQ_CLEAR_ADDR  = 8'he0;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'he4;
  localparam logic [7:0] CTRL_SET_ADDR   = 8'he8;
  localparam logic [7:0] CTRL_CLR_ADDR   = 8'hec;

  // ==========================================================================
  // Reset values and masks
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hfd;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  localparam logic [7:0] BYTE_MAX        = 8'hff;
  localparam logic [1:0] CLKSEL_RESET    = 2'h0;

  // ==========================================================================
  // Timebase dividers
  localparam logic [3:0] SYS_DIV_LAST    = 4'hb;
  localparam logic [2:0] EXT_DIV_LAST    = 3'h7;

  // ==========================================================================
  // Interrupt status, clear and enable layout
  localparam int         IRQ_BITS        = 3;
  localparam int         IRQ_HIGH        = 0;
  localparam int         IRQ_LOW         = 1;
  localparam int         IRQ_CAPTURE     = 2;
  localparam logic [2:0] IRQ_RESET       = 3'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic lfo_capture_enable;
    logic split_mode_select;
    logic run_control;
    logic unused_bit;
    logic ext_timebase_select;
  } ctrl_s;

  typedef struct packed {
    logic high_byte_clock_select;
    logic low_byte_clock_select;
  } clksel_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

endpackage

/* File: rtl/sync_edge.sv */
`timescale 1ns/1ns
module sync_edge (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic async_in,
  output logic      rise_out,
  output logic      fall_out
);

  logic meta;
  logic stable;
  logic last;

  // Two-stage synchroniser plus history stage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end else begin
      meta   <= async_in;
      stable <= meta;
      last   <= stable;
    end
  end

  // Single-cycle edge strobes from the stable stages
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      rise_out <= stable & ~last;
      fall_out <= ~stable & last;
    end
  end

endmodule // sync_edge

/* File: rtl/byte_counter.sv */
`timescale 1ns/1ns
module byte_counter (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       inc_in,
  input  wire logic       reload_on_wrap_in,
  input  wire logic [7:0] reload_value_in,
  input  wire logic       write_in,
  input  wire logic [7:0] write_value_in,
  output logic [7:0]      count_out,
  output logic            carry_out
);

  // Rollover from all ones on this increment
  assign carry_out = inc_in & (count_out == timer2_pkg::BYTE_MAX);

  // Count, reload on wrap, software load wins
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_out <= timer2_pkg::BYTE_ZERO;
    end else if (write_in) begin
      count_out <= write_value_in;
    end else if (carry_out) begin
      count_out <= reload_on_wrap_in ? reload_value_in : timer2_pkg::BYTE_ZERO;
    end else if (inc_in) begin
      count_out <= count_out + 8'h01;
    end
  end

endmodule // byte_counter

/* File: sim/timer2_checker.sv */
`timescale 1ns/1ns
module timer2_checker (
  input wire logic                clk_in,
  input wire logic                resetn_in,
  input wire timer2_pkg::wb_req_s wb_req_in,
  input wire timer2_pkg::wb_rsp_s wb_rsp_out,
  input wire logic                ext_osc_in,
  input wire logic                low_freq_oscillator_in,
  input wire logic                irq_out
);
  // ==========================================================
  // Clocking and bus sequences
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_req;
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  endsequence
  sequence s_rd(logic [7:0] a);
    wb_rsp_out.ack && !wb_req_in.we && wb_req_in.adr == a;
  endsequence
  sequence s_mask_wr;
    wb_rsp_out.ack && wb_req_in.we && wb_req_in.sel[0] && wb_req_in.adr == timer2_pkg::IRQ_ENABLE_ADDR;
  endsequence

  // ==========================================================
  // Assertions
  a_ack_after_req: assert property (s_req |=> wb_rsp_out.ack)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_rsp_out.ack |-> wb_req_in.stb && $past(wb_req_in.stb))
    else $error("ack without request");
  a_unused_bit_zero: assert property (s_rd(timer2_pkg::CTRL_ADDR) |-> !wb_rsp_out.dat[1])
    else $error("unused control bit read as one");
  a_ctrl_upper_zero: assert property (s_rd(timer2_pkg::CTRL_ADDR) |-> wb_rsp_out.dat[31:8] == 24'h0)
    else $error("control read has upper bits");
  a_clksel_upper_zero: assert property (s_rd(timer2_pkg::CLKSEL_ADDR) |-> wb_rsp_out.dat[31:2] == 30'h0)
    else $error("clock select read has upper bits");
  a_status_upper_zero: assert property (s_rd(timer2_pkg::IRQ_STATUS_ADDR) |-> wb_rsp_out.dat[31:3] == 29'h0)
    else $error("status read has upper bits");
  a_unmapped_zero: assert property (wb_rsp_out.ack && !wb_req_in.we && wb_req_in.adr == 8'h40
    |-> wb_rsp_out.dat == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_held: assert property ($changed(wb_rsp_out.dat) |-> wb_rsp_out.ack && !wb_req_in.we)
    else $error("read data changed outside a read");
  a_irq_masked: assert property (s_mask_wr ##0 wb_req_in.dat[2:0] == 3'h0 |=> !irq_out)
    else $error("interrupt with all enables off");
endmodule // timer2_checker

/* File: sim/timer2_control_logic_test.sv */
`timescale 1ns/1ns
module timer2_control_logic_test;
  logic                clk_in = 1'b0;
  logic                resetn_in = 1'b0;
  logic                ext_osc_in = 1'b0;
  logic                low_freq_oscillator = 1'b1;
  logic                irq;
  logic [2:0]          ph = 3'h0;
  logic [31:0]         rd;
  logic [31:0]         v;
  logic [71:0]         note;
  logic [71:0]         exp_q[$];
  int                  mismatches = 0;
  int                  n_tests = 0;
  int                  seed = 51;
  timer2_pkg::wb_req_s wb_req;
  timer2_pkg::wb_rsp_s wb_rsp;

  // ==========================================================
  // Clock and external oscillator, period of eight cycles
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    ph <= ph + 3'h1;
    ext_osc_in <= ph[2];
  end

  timer2_control_logic dut_u (
    .clk_in                 (clk_in),
    .resetn_in              (resetn_in),
    .wb_req_in              (wb_req),
    .wb_rsp_out             (wb_rsp),
    .ext_osc_in             (ext_osc_in),
    .low_freq_oscillator_in (low_freq_oscillator),
    .irq_out                (irq)
  );

  // ==========================================================
  // Verdict and comparison
  task stop_test;
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // ==========================================================
  // Bus cycle; reads leave a note for the monitor
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h3, dat: d};
    if (!w) exp_q.push_back({a, m, d & m});
    // Held until ack is sampled high; only the watchdog ends a hang
    do begin
      @(posedge clk_in);
    end while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk_in);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask
  task rdm(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, e, m);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Monitor takes the oldest note at each read answer
  always @(posedge clk_in) begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check($sformatf("reg %h", note[71:64]), note[31:0], wb_rsp.dat & note[63:32]);
    end
  end

  // Watchdog
  initial begin
    wait_n(30000);
    mismatches++;
    stop_test;
  end

  // ==========================================================
  // Main sequence
  initial begin
    wb_req = '0;
    wait_n(20);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    rdm(timer2_pkg::CTRL_ADDR, 32'h0, 32'hffffffff);
    rdm(timer2_pkg::CLKSEL_ADDR, 32'h0, 32'hffffffff);
    rdm(timer2_pkg::IRQ_STATUS_ADDR, 32'h0, 32'hffffffff);
    rdm(8'h40, 32'h0, 32'hffffffff);
    wr(timer2_pkg::CTRL_ADDR, 32'hff);
    rdm(timer2_pkg::CTRL_ADDR, 32'hfd, 32'hffffffff);
    v = $random(seed);
    wr(timer2_pkg::CTRL_ADDR, 32'h0);
    wr(timer2_pkg::RELOAD_ADDR, {16'h0, v[15:0]});
    rdm(timer2_pkg::RELOAD_ADDR, {16'h0, v[15:0]}, 32'hffffffff);
    // Sixteen-bit wrap with undivided clock
    wr(timer2_pkg::CLKSEL_ADDR, 32'h3);
    wr(timer2_pkg::RELOAD_ADDR, 32'h1200);
    wr(timer2_pkg::COUNT_ADDR, 32'hfff0);
    wr(timer2_pkg::CTRL_ADDR, 32'h04);
    wait_n(40);
    rdm(timer2_pkg::CTRL_ADDR, 32'hc4, 32'hff);
    rdm(timer2_pkg::COUNT_ADDR, 32'h1200, 32'hff00);
    // Interrupt raise, clear, mask
    check("irq", 32'h0, {31'h0, irq});
    wr(timer2_pkg::IRQ_ENABLE_ADDR, 32'h1);
    check("irq", 32'h1, {31'h0, irq});
    wr(timer2_pkg::IRQ_CLEAR_ADDR, 32'h7);
    check("irq", 32'h0, {31'h0, irq});
    rdm(timer2_pkg::CTRL_ADDR, 32'h80, 32'h80);
    wr(timer2_pkg::IRQ_ENABLE_ADDR, 32'h2);
    wait_n(300);
    check("irq", 32'h0, {31'h0, irq});
    wr(timer2_pkg::CTRL_ADDR, 32'h24);
    check("irq", 32'h1, {31'h0, irq});
    wr(timer2_pkg::IRQ_ENABLE_ADDR, 32'h0);
    check("irq", 32'h0, {31'h0, irq});
    // Split mode, high byte stopped then running
    wr(timer2_pkg::CTRL_ADDR, 32'h08);
    wr(timer2_pkg::RELOAD_ADDR, 32'h3380);
    wr(timer2_pkg::COUNT_ADDR, 32'h10f0);
    wait_n(40);
    rdm(timer2_pkg::COUNT_ADDR, 32'h1080, 32'hff80);
    rdm(timer2_pkg::CTRL_ADDR, 32'h48, 32'hff);
    wr(timer2_pkg::CTRL_ADDR, 32'h0c);
    wait_n(300);
    rdm(timer2_pkg::CTRL_ADDR, 32'hc0, 32'hc0);
    // Capture on oscillator falling edge
    wr(timer2_pkg::CTRL_ADDR, 32'h10);
    wr(timer2_pkg::COUNT_ADDR, 32'habcd);
    wr(timer2_pkg::IRQ_CLEAR_ADDR, 32'h7);
    wr(timer2_pkg::IRQ_ENABLE_ADDR, 32'h4);
    low_freq_oscillator <= 1'b0;
    wait_n(10);
    rdm(timer2_pkg::RELOAD_ADDR, 32'habcd, 32'hffff);
    rdm(timer2_pkg::IRQ_STATUS_ADDR, 32'h5, 32'h7);
    rdm(timer2_pkg::CTRL_ADDR, 32'h90, 32'hff);
    check("irq", 32'h1, {31'h0, irq});
    low_freq_oscillator <= 1'b1;
    // Bit-set and bit-clear aliases of the control register
    wr(timer2_pkg::CTRL_CLR_ADDR, 32'h80);
    wr(timer2_pkg::CTRL_SET_ADDR, 32'h22);
    rdm(timer2_pkg::CTRL_SET_ADDR, 32'h30, 32'hff);
    // Divided timebases: system by 12, external by 8 on split low byte
    wr(timer2_pkg::CLKSEL_ADDR, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(timer2_pkg::CTRL_ADDR, (i == 1) ? 32'h09 : 32'h04);
      wr(timer2_pkg::COUNT_ADDR, 32'h0);
      wait_n(1200);
      rdm(timer2_pkg::COUNT_ADDR, 32'h0, 32'h0);
      v = (i == 1) ? 32'd19 : 32'd100;
      n_tests++;
      if ((rd <= v + 3 && rd + 3 >= v) !== 1'b1) begin
        mismatches++;
        $display("CHECK FAILED timebase exp %0d got %0d", v, rd);
      end
    end
    stop_test;
  end
endmodule // timer2_control_logic_test

bind timer2_control_logic timer2_checker chk_u (
  .clk_in                 (clk_in),
  .resetn_in              (resetn_in),
  .wb_req_in              (wb_req_in),
  .wb_rsp_out             (wb_rsp_out),
  .ext_osc_in             (ext_osc_in),
  .low_freq_oscillator_in (low_freq_oscillator_in),
  .irq_out                (irq_out)
);
